// >>> src/mesi_map.vh
`ifndef MESI_MAP_VH
`define MESI_MAP_VH

// Register word offsets (bus byte address bits [4:2])
`define MESI_OFF_TXQP      4'h0
`define MESI_OFF_RXSTAT    4'h1
`define MESI_OFF_EVENTS    4'h2
`define MESI_OFF_ENSET     4'h3
`define MESI_OFF_ENCLR     4'h4
`define MESI_OFF_MASK      4'h5
`define MESI_OFF_PAUSE     4'h6
`define MESI_OFF_CTRL      4'h7

// Receive status bit positions
`define MESI_RS_NOBUF      0
`define MESI_RS_STORED     1
`define MESI_RS_OVFL       2
`define MESI_RS_W          3

// Event bit positions
`define MESI_EV_MGMT       0
`define MESI_EV_RXDONE     1
`define MESI_EV_RXOWN      2
`define MESI_EV_TXOWN      3
`define MESI_EV_TXUND      4
`define MESI_EV_RETRY      5
`define MESI_EV_TXEXH      6
`define MESI_EV_TXDONE     7
`define MESI_EV_RXOVF      10
`define MESI_EV_BUSERR     11
`define MESI_EV_PSEEN      12
`define MESI_EV_PEXP       13
`define MESI_EV_W          14
`define MESI_EV_VALID      14'h3CFF

// Control register bits
`define MESI_CT_FAST       0

// Reset values
`define MESI_RST_EV        14'h0000
`define MESI_RST_MASK      14'h0000
`define MESI_RST_RS        3'h0
`define MESI_RST_PTR       32'h00000000
`define MESI_RST_PAUSE     16'h0000

// Timing: 512 bit times per pause quantum
`define MESI_PAUSE_BITS    10'h200
`define MESI_QCNT_W        10

`endif

// >>> src/mesi_quantum.v
`timescale 1ns/1ps
`include "mesi_map.vh"

// Pause quantum divider: one pulse per 512 bit enables, one per bit enable when fast_i is set
module mesi_quantum (
   input  wire       clk_i,      // System clock
   input  wire       rst_i,      // Sync reset
   input  wire       bit_en_i,   // One bit time elapsed
   input  wire       fast_i,     // Test mode: every bit
   output reg        tick_o      // Quantum pulse
);
   reg [`MESI_QCNT_W-1:0] cnt_r;

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r  <= {`MESI_QCNT_W{1'b0}};
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (bit_en_i) begin
            if (fast_i || cnt_r == `MESI_PAUSE_BITS - 10'h001) begin
               cnt_r  <= {`MESI_QCNT_W{1'b0}};
               tick_o <= 1'b1;
            end else begin
               cnt_r  <= cnt_r + 10'h001;
            end
         end
      end
   end
endmodule

// >>> src/mesi_top.v
`timescale 1ns/1ps
`include "mesi_map.vh"

// Function
// - TX pointer reads first descriptor of frame
// - RX flags clear only by writing one
// - No-buffer flag set on every failed fetch
// - Refetch descriptor each new frame until owned
// - Frame-stored flag set after frame stored
// - Overflow flag on late grant/bus error; recover
// - Event register clears on read
// - Management-done event bit 0
// - Receive-complete event bit 1
// - RX used-bit-read event bit 2
// - TX used-bit-read event bit 3
// - TX underrun event bit 4, incl pointer write
// - TX exhausted bit 6, retry cap bit 5
// - Transmit-complete event bit 7
// - RX overflow event when flag sets
// - Bus-error event bit 11
// - Pause-seen event bit 12
// - Pause-expired event bit 13 at zero
// - Enable register write-only, ones enable
// - Disable register write-only, ones disable
// - Mask register read-only reports enables
// - Pause counter decrements every 512 bits, every bit in fast mode
module mesi_top (
   input  wire        REF_CLK_I,          // 25 MHz clock
   input  wire        RST_I,              // Sync reset, high
   input  wire [4:0]  AVS_ADDRESS_I,      // Byte address
   input  wire        AVS_READ_I,         // Read strobe
   input  wire        AVS_WRITE_I,        // Write strobe
   input  wire [31:0] AVS_WRITEDATA_I,    // Write data
   input  wire [3:0]  AVS_BYTEENABLE_I,   // Byte lanes
   output reg  [31:0] AVS_READDATA_O,     // Read data
   output reg         AVS_WAITREQUEST_O,  // Wait request
   input  wire        MGMT_DONE_I,        // PHY mgmt op finished
   input  wire        RX_FRAME_START_I,   // New RX frame begins
   input  wire        RX_DESC_VALID_I,    // RX descriptor fetched
   input  wire        RX_DESC_USED_I,     // Fetched desc used bit
   input  wire        RX_STORED_I,        // RX frame in memory
   input  wire        RX_LATE_GRANT_I,    // RX bus grant late
   input  wire        RX_BUS_ERR_I,       // RX bus error
   input  wire        TX_DESC_VALID_I,    // TX descriptor fetched
   input  wire        TX_DESC_USED_I,     // TX desc used bit
   input  wire        TX_MID_FRAME_I,     // TX inside a frame
   input  wire        TX_FRAME_START_I,   // TX starts a frame
   input  wire [31:0] TX_DESC_ADDR_I,     // Current TX desc addr
   input  wire        TX_LATE_DATA_I,     // TX data not in time
   input  wire        TX_BUS_ERR_I,       // TX bus error
   input  wire        TX_RETRY_CAP_I,     // Retry limit hit
   input  wire        TX_EXHAUSTED_I,     // Buffers out mid frame
   input  wire        TX_DONE_I,          // TX frame finished
   input  wire        PAUSE_RX_I,         // Valid pause frame
   input  wire [15:0] PAUSE_TIME_I,       // Received pause time
   input  wire        BIT_EN_I,           // One bit time pulse
   output reg         RX_REFETCH_O,       // Re-read RX desc pointer
   output reg         RX_RECOVER_O,       // Recover RX buffer
   output reg  [31:0] TXQ_BASE_O,         // Written TX queue start
   output reg         TXQ_LOAD_O,         // TX pointer written
   output reg         PAUSE_ACTIVE_O,     // Pause counter nonzero
   output reg         IRQ_O               // Interrupt, high
);

   reg  [31:0] tx_queue_pointer_r;
   reg  [2:0]  rx_status_r;
   reg  [2:0]  rx_status_nxt;
   reg  [13:0] irq_events_r;
   reg  [13:0] irq_events_nxt;
   reg  [13:0] irq_mask_r;
   reg  [13:0] irq_mask_nxt;
   reg  [15:0] pause_cnt_r;
   reg  [15:0] pause_cnt_nxt;
   reg         fast_r;
   reg         nobuf_wait_r;
   reg         ack_r;
   reg  [31:0] rdata_nxt;
   reg  [13:0] ev_set;
   reg  [2:0]  rs_set;
   reg         pexp;
   wire        quantum;
   wire [3:0]  widx;
   wire        wr_go;
   wire        rd_go;
   wire [31:0] wmask;

   // Byte lanes expand to a bit mask
   function [31:0] lane_mask;
      input [3:0] be;
      begin
         lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   // Word index from byte address
   function [3:0] word_idx;
      input [4:0] addr;
      begin
         word_idx = {1'b0, addr[4:2]};
      end
   endfunction

   // Reads capture and clear on one edge so no event slips between
   // Writes act only on the edge that sees waitrequest low
   assign widx  = word_idx(AVS_ADDRESS_I);
   assign wmask = lane_mask(AVS_BYTEENABLE_I);
   assign wr_go = AVS_WRITE_I & ack_r;
   assign rd_go = AVS_READ_I & ~ack_r;

   mesi_quantum u_quantum (
      .clk_i    (REF_CLK_I),
      .rst_i    (RST_I),
      .bit_en_i (BIT_EN_I),
      .fast_i   (fast_r),
      .tick_o   (quantum)
   );

   always @* begin
      rs_set = 3'h0;
      ev_set = 14'h0000;
      // Failed fetch: desc owned by software
      rs_set[`MESI_RS_NOBUF] = RX_DESC_VALID_I & RX_DESC_USED_I;
      rs_set[`MESI_RS_STORED] = RX_STORED_I;
      rs_set[`MESI_RS_OVFL] = RX_LATE_GRANT_I | RX_BUS_ERR_I;
      ev_set[`MESI_EV_MGMT]   = MGMT_DONE_I;
      ev_set[`MESI_EV_RXDONE] = RX_STORED_I;
      ev_set[`MESI_EV_RXOWN]  = RX_DESC_VALID_I & RX_DESC_USED_I;
      ev_set[`MESI_EV_TXOWN]  = TX_DESC_VALID_I & TX_DESC_USED_I;
      ev_set[`MESI_EV_TXUND]  = TX_LATE_DATA_I | TX_BUS_ERR_I |
                                (TX_DESC_VALID_I & TX_DESC_USED_I &
                                 TX_MID_FRAME_I) |
                                (wr_go && widx == `MESI_OFF_TXQP);
      ev_set[`MESI_EV_RETRY]  = TX_RETRY_CAP_I;
      ev_set[`MESI_EV_TXEXH]  = TX_EXHAUSTED_I;
      ev_set[`MESI_EV_TXDONE] = TX_DONE_I;
      ev_set[`MESI_EV_RXOVF]  = rs_set[`MESI_RS_OVFL];
      ev_set[`MESI_EV_BUSERR] = RX_BUS_ERR_I | TX_BUS_ERR_I;
      ev_set[`MESI_EV_PSEEN]  = PAUSE_RX_I;
      ev_set[`MESI_EV_PEXP]   = pexp;
   end

   // Pause counter steps down once per quantum
   always @* begin
      pause_cnt_nxt = pause_cnt_r;
      pexp = 1'b0;
      if (PAUSE_RX_I) begin
         pause_cnt_nxt = PAUSE_TIME_I;
      end else if (quantum && pause_cnt_r != 16'h0000) begin
         pause_cnt_nxt = pause_cnt_r - 16'h0001;
         pexp = (pause_cnt_r == 16'h0001);
      end
   end

   always @* begin
      rx_status_nxt = rx_status_r;
      if (wr_go && widx == `MESI_OFF_RXSTAT) begin
         // Ones clear, zeros keep, nothing sets
         rx_status_nxt = rx_status_r &
                         ~(AVS_WRITEDATA_I[2:0] & wmask[2:0]);
      end
      rx_status_nxt = rx_status_nxt | rs_set;

      irq_events_nxt = irq_events_r;
      if (rd_go && widx == `MESI_OFF_EVENTS) begin
         irq_events_nxt = `MESI_RST_EV;
      end
      irq_events_nxt = (irq_events_nxt | ev_set) &
                       `MESI_EV_VALID;

      irq_mask_nxt = irq_mask_r;
      if (wr_go && widx == `MESI_OFF_ENSET) begin
         irq_mask_nxt = irq_mask_r |
                        (AVS_WRITEDATA_I[13:0] & wmask[13:0] &
                         `MESI_EV_VALID);
      end
      if (wr_go && widx == `MESI_OFF_ENCLR) begin
         irq_mask_nxt = irq_mask_r &
                        ~(AVS_WRITEDATA_I[13:0] & wmask[13:0]);
      end

      rdata_nxt = 32'h00000000;
      case (widx)
         `MESI_OFF_TXQP:   rdata_nxt = tx_queue_pointer_r;
         `MESI_OFF_RXSTAT: rdata_nxt = {29'h0, rx_status_r};
         `MESI_OFF_EVENTS: rdata_nxt = {18'h0, irq_events_r};
         `MESI_OFF_MASK:   rdata_nxt = {18'h0, irq_mask_r};
         `MESI_OFF_PAUSE:  rdata_nxt = {16'h0, pause_cnt_r};
         `MESI_OFF_CTRL:   rdata_nxt = {31'h0, fast_r};
         default:          rdata_nxt = 32'h00000000;
      endcase
   end

   always @(posedge REF_CLK_I) begin
      if (RST_I) begin
         tx_queue_pointer_r <= `MESI_RST_PTR;
         rx_status_r        <= `MESI_RST_RS;
         irq_events_r       <= `MESI_RST_EV;
         irq_mask_r         <= `MESI_RST_MASK;
         pause_cnt_r        <= `MESI_RST_PAUSE;
         fast_r             <= 1'b0;
         nobuf_wait_r       <= 1'b0;
         ack_r              <= 1'b0;
         AVS_READDATA_O     <= 32'h00000000;
         AVS_WAITREQUEST_O  <= 1'b1;
         RX_REFETCH_O       <= 1'b0;
         RX_RECOVER_O       <= 1'b0;
         TXQ_BASE_O         <= `MESI_RST_PTR;
         TXQ_LOAD_O         <= 1'b0;
         PAUSE_ACTIVE_O     <= 1'b0;
         IRQ_O              <= 1'b0;
      end else begin
         rx_status_r    <= rx_status_nxt;
         irq_events_r   <= irq_events_nxt;
         irq_mask_r     <= irq_mask_nxt;
         pause_cnt_r    <= pause_cnt_nxt;
         PAUSE_ACTIVE_O <= (pause_cnt_nxt != 16'h0000);
         IRQ_O          <= |(irq_events_nxt & irq_mask_nxt);
         RX_RECOVER_O   <= rs_set[`MESI_RS_OVFL];
         TXQ_LOAD_O     <= 1'b0;
         // Latch pointer only at frame start, not per fetch
         if (TX_FRAME_START_I) begin
            tx_queue_pointer_r <= TX_DESC_ADDR_I;
         end
         if (wr_go && widx == `MESI_OFF_TXQP) begin
            tx_queue_pointer_r <= AVS_WRITEDATA_I;
            TXQ_BASE_O         <= AVS_WRITEDATA_I;
            TXQ_LOAD_O         <= 1'b1;
         end
         if (wr_go && widx == `MESI_OFF_CTRL && AVS_BYTEENABLE_I[0]) begin
            fast_r <= AVS_WRITEDATA_I[`MESI_CT_FAST];
         end
         // Retry descriptor fetch at every frame start after a miss
         if (rs_set[`MESI_RS_NOBUF]) begin
            nobuf_wait_r <= 1'b1;
         end else if (RX_DESC_VALID_I && !RX_DESC_USED_I) begin
            nobuf_wait_r <= 1'b0;
         end
         RX_REFETCH_O <= nobuf_wait_r & RX_FRAME_START_I;
         ack_r <= (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
         AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & ~ack_r);
         if (rd_go) begin
            AVS_READDATA_O <= rdata_nxt;
         end
      end
   end
endmodule

// >>> testbench/mesi_properties.sv
`timescale 1ns/1ps
module mesi_checker (
   input wire        REF_CLK_I,          // Clock
   input wire        RST_I,              // Sync reset
   input wire [4:0]  AVS_ADDRESS_I,      // Byte address
   input wire        AVS_READ_I,         // Read strobe
   input wire        AVS_WRITE_I,        // Write strobe
   input wire [31:0] AVS_WRITEDATA_I,    // Write data
   input wire [3:0]  AVS_BYTEENABLE_I,   // Byte lanes
   input wire [31:0] AVS_READDATA_O,     // Read data
   input wire        AVS_WAITREQUEST_O,  // Wait request
   input wire        RX_FRAME_START_I,   // RX frame start
   input wire        RX_LATE_GRANT_I,    // RX grant late
   input wire        RX_BUS_ERR_I,       // RX bus error
   input wire        PAUSE_RX_I,         // Pause frame
   input wire [15:0] PAUSE_TIME_I,       // Pause time
   input wire        RX_REFETCH_O,       // Refetch pulse
   input wire        RX_RECOVER_O,       // Recover pulse
   input wire [31:0] TXQ_BASE_O,         // Queue start
   input wire        TXQ_LOAD_O,         // Pointer written
   input wire        PAUSE_ACTIVE_O,     // Pause running
   input wire        IRQ_O               // Interrupt
);
   wire       req = (AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O;
   wire       rdn = AVS_READ_I & !AVS_WAITREQUEST_O;
   wire       wfull = AVS_WRITE_I & !AVS_WAITREQUEST_O & &AVS_BYTEENABLE_I;
   wire [2:0] wa = AVS_ADDRESS_I[4:2];
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   a_wait_answer: assert property (
      req |=> !AVS_WAITREQUEST_O) else $error("no bus answer");
   a_ptr_load: assert property (
      wfull && wa == 3'h0 |=> TXQ_LOAD_O &&
      TXQ_BASE_O == $past(AVS_WRITEDATA_I)) else $error("bad ptr load");
   a_refetch_cause: assert property (
      RX_REFETCH_O |-> $past(RX_FRAME_START_I)) else $error("bad refetch");
   a_recover_cause: assert property (
      RX_RECOVER_O == $past(RX_LATE_GRANT_I | RX_BUS_ERR_I))
      else $error("bad recover");
   a_pause_load: assert property (
      PAUSE_RX_I && PAUSE_TIME_I != 16'h0000 |=> PAUSE_ACTIVE_O)
      else $error("pause not loaded");
   a_disable_all: assert property (
      wfull && wa == 3'h4 && AVS_WRITEDATA_I[13:0] == 14'h3FFF |=> !IRQ_O)
      else $error("irq after disable");
   a_event_reserved: assert property (
      rdn && wa == 3'h2 |-> AVS_READDATA_O[31:14] == 18'h00000 &&
      AVS_READDATA_O[9:8] == 2'h0) else $error("reserved event bits");
   a_wo_zero: assert property (
      rdn && (wa == 3'h3 || wa == 3'h4) |-> AVS_READDATA_O == 32'h00000000)
      else $error("write-only reg read nonzero");
   c_event_read: cover property (rdn && wa == 3'h2);
   c_irq: cover property (IRQ_O);
   c_refetch: cover property (RX_REFETCH_O);
endmodule

bind mesi_top mesi_checker u_chk (.REF_CLK_I, .RST_I, .AVS_ADDRESS_I,
   .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I,
   .AVS_READDATA_O, .AVS_WAITREQUEST_O, .RX_FRAME_START_I,
   .RX_LATE_GRANT_I, .RX_BUS_ERR_I, .PAUSE_RX_I, .PAUSE_TIME_I,
   .RX_REFETCH_O, .RX_RECOVER_O, .TXQ_BASE_O, .TXQ_LOAD_O,
   .PAUSE_ACTIVE_O, .IRQ_O);

// >>> testbench/test_mac_event_status_irq.sv
`timescale 1ns/1ps
module test_mac_event_status_irq;
   logic        clk = 0, rst = 1, rd = 0, wr = 0, wq, irq, rf, pact;
   logic [4:0]  adr = 0;
   logic [31:0] wd = 0, tda = 0, q, rdat;
   logic [15:0] pt = 0;
   logic [17:0] ev = 0;
   int          err_total = 0, checks = 0;
   logic [17:0] em [13] = '{18'h00001, 18'h00002, 18'h00004, 18'h00008,
      18'h00010, 18'h00020, 18'h00040, 18'h00080, 18'h00100, 18'h00200,
      18'h03000, 18'h0C000, 18'h1C000};
   logic [13:0] ee [13] = '{14'h0001, 14'h0002, 14'h0400, 14'h0C00,
      14'h0010, 14'h0810, 14'h0020, 14'h0040, 14'h0080, 14'h1000,
      14'h0004, 14'h0008, 14'h0018};
   logic [2:0]  er [13] = '{3'h0, 3'h2, 3'h4, 3'h4, 3'h0, 3'h0, 3'h0,
      3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0};
   mesi_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
      .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(wq), .MGMT_DONE_I(ev[0]), .RX_STORED_I(ev[1]),
      .RX_LATE_GRANT_I(ev[2]), .RX_BUS_ERR_I(ev[3]),
      .TX_LATE_DATA_I(ev[4]), .TX_BUS_ERR_I(ev[5]),
      .TX_RETRY_CAP_I(ev[6]), .TX_EXHAUSTED_I(ev[7]), .TX_DONE_I(ev[8]),
      .PAUSE_RX_I(ev[9]), .RX_FRAME_START_I(ev[10]),
      .TX_FRAME_START_I(ev[11]), .RX_DESC_VALID_I(ev[12]),
      .RX_DESC_USED_I(ev[13]), .TX_DESC_VALID_I(ev[14]),
      .TX_DESC_USED_I(ev[15]), .TX_MID_FRAME_I(ev[16]),
      .BIT_EN_I(ev[17]), .PAUSE_TIME_I(pt), .TX_DESC_ADDR_I(tda),
      .RX_REFETCH_O(rf), .RX_RECOVER_O(), .TXQ_BASE_O(), .TXQ_LOAD_O(),
      .PAUSE_ACTIVE_O(pact), .IRQ_O(irq));
   always #20 clk = ~clk;
   // Values read right after an edge are those the edge sampled
   task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      q = rdat;
      rd <= 0;
      wr <= 0;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task rc(input logic [4:0] a, input logic [31:0] e);
      acc(0, a, 32'h0);
      chk(q, e);
   endtask
   task pl(input logic [17:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 0;
   endtask
   task complete_run;
      $display("err_total %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk);
      err_total++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      rc(5'h14, 32'h0);
      for (int i = 0; i < 13; i++) begin
         pl(em[i]);
         rc(5'h08, {18'h0, ee[i]});
         rc(5'h04, {29'h0, er[i]});
         acc(1, 5'h04, 32'h7);
      end
      rc(5'h08, 32'h0);
      pl(18'h00002);
      acc(1, 5'h04, 32'h5);
      rc(5'h04, 32'h2);
      acc(1, 5'h04, 32'h2);
      rc(5'h04, 32'h0);
      // Frame stored on the same edge as its clearing write
      fork
         acc(1, 5'h04, 32'h2);
         begin
            @(posedge clk);
            pl(18'h00002);
         end
      join
      rc(5'h04, 32'h2);
      rc(5'h08, 32'h2);
      acc(1, 5'h0C, 32'h1);
      rc(5'h14, 32'h1);
      rc(5'h0C, 32'h0);
      pl(18'h00100);
      @(posedge clk);
      chk(irq, 1'b0);
      pl(18'h00001);
      @(posedge clk);
      chk(irq, 1'b1);
      rc(5'h08, 32'h81);
      chk(irq, 1'b0);
      acc(1, 5'h10, 32'h3FFF);
      rc(5'h14, 32'h0);
      acc(1, 5'h14, 32'hFFFF);
      rc(5'h14, 32'h0);
      acc(1, 5'h00, 32'h400);
      rc(5'h08, 32'h10);
      tda <= 32'h1238;
      pl(18'h00800);
      rc(5'h00, 32'h1238);
      acc(1, 5'h1C, 32'h1);
      pt <= 16'h2;
      pl(18'h00200);
      repeat (2) pl(18'h20000);
      repeat (4) @(posedge clk);
      rc(5'h08, 32'h3000);
      acc(1, 5'h1C, 32'h0);
      pt <= 16'h1;
      pl(18'h00200);
      @(posedge clk);
      ev <= 18'h20000;
      repeat (505) @(posedge clk);
      chk(pact, 1'b1);
      repeat (15) @(posedge clk);
      chk(pact, 1'b0);
      ev <= 0;
      pl(18'h03000);
      pl(18'h00400);
      @(posedge clk);
      chk(rf, 1'b1);
      pl(18'h01000);
      pl(18'h00400);
      @(posedge clk);
      chk(rf, 1'b0);
      complete_run();
   end
endmodule
